// ---- rtl/swbc_pkg.sv ----
// constants and types shared by the write-back buffered sram controller
`default_nettype none
package swbc_pkg;
   // ----------------------------------------------------------------
   // access sizes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SWBC_SZ_BYTE,
      SWBC_SZ_HALF,
      SWBC_SZ_WORD
   } swbc_size_e;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int SWBC_KB_64 = 64;
   localparam int SWBC_KB_32 = 32;
   localparam int SWBC_KB_16 = 16;
   localparam int SWBC_BYTES_PER_KB = 1024;
   localparam int SWBC_DATA_W = 32;
   localparam int SWBC_LANES = 4;
   localparam int SWBC_LANE_W = 8;
   localparam int SWBC_ADDR_W = 16;
   localparam int SWBC_BYTE_SEL_W = 2;

   localparam logic [3:0] SWBC_BE_NONE = 4'h0;
   localparam logic [3:0] SWBC_BE_BYTE = 4'h1;
   localparam logic [3:0] SWBC_BE_HALF = 4'h3;
   localparam logic [3:0] SWBC_BE_WORD = 4'hf;

   // lane enables for a size at a byte offset, lowest address = lowest lane
   function automatic logic [3:0] swbc_lanes(input swbc_size_e sz, input logic [1:0] ofs);
      logic [3:0] base;
      base = SWBC_BE_WORD;
      case (sz)
         SWBC_SZ_BYTE: base = SWBC_BE_BYTE;
         SWBC_SZ_HALF: base = SWBC_BE_HALF;
         default: base = SWBC_BE_WORD;
      endcase
      if (sz == SWBC_SZ_WORD) begin
         swbc_lanes = base;
      end else begin
         swbc_lanes = 4'(base << ofs);
      end
   endfunction : swbc_lanes

   // expand 4 lane enables into a 32-bit bit mask
   function automatic logic [31:0] swbc_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < SWBC_LANES; i++) begin
         m[i*SWBC_LANE_W +: SWBC_LANE_W] = {SWBC_LANE_W{be[i]}};
      end
      swbc_mask = m;
   endfunction : swbc_mask
endpackage : swbc_pkg
`default_nettype wire

// ---- rtl/swbc_ram.sv ----
// word-wide static ram array with per-lane write and registered read
`default_nettype none
module swbc_ram
   import swbc_pkg::*;
#(
   parameter int DEPTH = 16384,
   parameter int AW = 14
) (
   // clock
   input wire logic ref_clk,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [3:0] wr_be,
   input wire logic [31:0] wr_data,
   // read port
   input wire logic [AW-1:0] rd_idx,
   output logic [31:0] rd_data_ff
);
   logic [31:0] mem [DEPTH];

   // ----------------------------------------------------------------
   // array
   // ----------------------------------------------------------------
   // no reset: contents survive chip reset like real sram
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < SWBC_LANES; i++) begin
         if (wr_en && wr_be[i]) begin
            mem[wr_idx][i*SWBC_LANE_W +: SWBC_LANE_W] <= wr_data[i*SWBC_LANE_W +: SWBC_LANE_W];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      rd_data_ff <= mem[rd_idx];
   end
endmodule : swbc_ram
`default_nettype wire

// ---- rtl/swbc_ctrl.sv ----
// sram controller top: lane steering, one-entry write-back buffer, read merge
`default_nettype none
// What this block does
// R1: byte, halfword, word accesses with lane steering
// R2: array size is a 64/32/16 KB parameter
// R3: lowest byte address maps to low lane
// R4: writes never stall; taken into buffer
// R5: buffer holds newest write address, data, lanes
// R6: commit only when next write arrives
// R7: reset drops pending write uncommitted
// R8: software forces commit with dummy write
// R9: reads matching buffer see merged buffered bytes
module swbc_ctrl
   import swbc_pkg::*;
#(
   parameter int SIZE_KB = SWBC_KB_64
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // request from core
   input wire logic req_valid,
   input wire logic req_write,
   input wire swbc_size_e req_size,
   input wire logic [SWBC_ADDR_W-1:0] req_addr,
   input wire logic [31:0] req_wdata,
   // answer to core
   output logic req_ready_ff,
   output logic rsp_valid_ff,
   output logic [31:0] rsp_rdata_ff
);
   localparam int DEPTH = SIZE_KB * SWBC_BYTES_PER_KB / SWBC_LANES;
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // size check
   // ----------------------------------------------------------------
   initial begin
      if (SIZE_KB != SWBC_KB_64 && SIZE_KB != SWBC_KB_32 && SIZE_KB != SWBC_KB_16) begin
         $error("unsupported array size"); // R2
      end
   end

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   logic [AW-1:0] req_idx;
   logic [1:0] req_ofs;
   logic [3:0] req_be;
   logic [31:0] req_lane_data;
   logic wr_take;
   logic rd_take;

   assign req_idx = req_addr[SWBC_BYTE_SEL_W +: AW];
   assign req_ofs = req_addr[SWBC_BYTE_SEL_W-1:0];
   assign req_be = swbc_lanes(req_size, req_ofs); // R1 R3
   // narrow write data arrives in the low bits and is shifted to its lanes
   assign req_lane_data = (req_size == SWBC_SZ_WORD) ? req_wdata :
                          32'(req_wdata << {req_ofs, 3'h0}); // R3
   assign wr_take = req_valid && req_write;
   assign rd_take = req_valid && !req_write;

   // ----------------------------------------------------------------
   // write-back buffer
   // ----------------------------------------------------------------
   logic buf_valid_ff;
   logic [AW-1:0] buf_idx_ff;
   logic [3:0] buf_be_ff;
   logic [31:0] buf_data_ff;

   // reset clears the valid flag and the held index, lanes and data: the held write is lost, never committed
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         buf_valid_ff <= 1'b0; // R7
      end else if (wr_take) begin
         buf_valid_ff <= 1'b1; // R4
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         buf_idx_ff <= '0;
         buf_be_ff <= SWBC_BE_NONE;
         buf_data_ff <= '0;
      end else if (wr_take) begin
         buf_idx_ff <= req_idx; // R5
         buf_be_ff <= req_be;
         buf_data_ff <= req_lane_data;
      end
   end

   // ----------------------------------------------------------------
   // array and commit
   // ----------------------------------------------------------------
   logic commit;
   logic [31:0] ram_rdata;

   // a read never commits; only a new write pushes the old one out
   assign commit = wr_take && buf_valid_ff; // R6

   swbc_ram #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_ram (
      .ref_clk(ref_clk),
      .wr_en(commit),
      .wr_idx(buf_idx_ff),
      .wr_be(buf_be_ff),
      .wr_data(buf_data_ff),
      .rd_idx(req_idx),
      .rd_data_ff(ram_rdata)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic rd_pend_ff;
   logic [1:0] rd_ofs_ff;
   swbc_size_e rd_size_ff;
   logic rd_hit_ff;
   logic [3:0] hit_be_ff;
   logic [31:0] hit_data_ff;
   logic [31:0] merged;
   logic [31:0] shifted;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_pend_ff <= 1'b0;
      end else begin
         rd_pend_ff <= rd_take;
      end
   end

   // buffer snapshot taken with the read: array read returns next cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_ofs_ff <= '0;
         rd_size_ff <= SWBC_SZ_WORD;
         rd_hit_ff <= 1'b0;
         hit_be_ff <= SWBC_BE_NONE;
         hit_data_ff <= '0;
      end else if (rd_take) begin
         rd_ofs_ff <= req_ofs;
         rd_size_ff <= req_size;
         rd_hit_ff <= buf_valid_ff && (buf_idx_ff == req_idx); // R9
         hit_be_ff <= buf_be_ff;
         hit_data_ff <= buf_data_ff;
      end
   end

   always_comb begin
      merged = ram_rdata;
      if (rd_hit_ff) begin
         merged = (ram_rdata & ~swbc_mask(hit_be_ff)) | (hit_data_ff & swbc_mask(hit_be_ff)); // R9
      end
      shifted = (rd_size_ff == SWBC_SZ_WORD) ? merged : 32'(merged >> {rd_ofs_ff, 3'h0}); // R3
      case (rd_size_ff)
         SWBC_SZ_BYTE: shifted = shifted & swbc_mask(SWBC_BE_BYTE); // R1
         SWBC_SZ_HALF: shifted = shifted & swbc_mask(SWBC_BE_HALF); // R1
         default: shifted = shifted;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= '0;
      end else begin
         rsp_valid_ff <= rd_pend_ff;
         if (rd_pend_ff) begin
            rsp_rdata_ff <= shifted;
         end
      end
   end

   // never stalls: ready rises after reset and stays
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         req_ready_ff <= 1'b0;
      end else begin
         req_ready_ff <= 1'b1; // R4
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_wr_never_stalls;
      @(posedge ref_clk) disable iff (!rstn) req_ready_ff |=> req_ready_ff;
   endproperty
   a_wr_never_stalls: assert property (p_wr_never_stalls) else $error("ready dropped"); // R4

   property p_buf_holds_last;
      @(posedge ref_clk) disable iff (!rstn)
         wr_take |=> buf_valid_ff && buf_idx_ff == $past(req_idx) && buf_be_ff == $past(req_be);
   endproperty
   a_buf_holds_last: assert property (p_buf_holds_last) else $error("buffer not newest"); // R5

   property p_no_commit_on_read;
      @(posedge ref_clk) disable iff (!rstn) rd_take |-> !commit;
   endproperty
   a_no_commit_on_read: assert property (p_no_commit_on_read) else $error("read committed"); // R6

   property p_commit_on_write;
      @(posedge ref_clk) disable iff (!rstn) (wr_take && buf_valid_ff) |-> commit;
   endproperty
   a_commit_on_write: assert property (p_commit_on_write) else $error("write missed commit"); // R6

   property p_buf_stable_reads;
      @(posedge ref_clk) disable iff (!rstn)
         (buf_valid_ff && !wr_take) |=> $stable(buf_data_ff) && $stable(buf_idx_ff);
   endproperty
   a_buf_stable_reads: assert property (p_buf_stable_reads) else $error("buffer changed"); // R6

   property p_read_latency;
      @(posedge ref_clk) disable iff (!rstn) rd_take |-> ##2 rsp_valid_ff;
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read answer late"); // R1

   property p_byte_upper_zero;
      @(posedge ref_clk) disable iff (!rstn)
         (rd_take && req_size == SWBC_SZ_BYTE) |-> ##2 rsp_rdata_ff[31:8] == 24'h000000;
   endproperty
   a_byte_upper_zero: assert property (p_byte_upper_zero) else $error("byte read upper set"); // R1

   property p_hit_returns_buffer;
      @(posedge ref_clk) disable iff (!rstn)
         (rd_take && req_size == SWBC_SZ_WORD && buf_valid_ff && buf_idx_ff == req_idx
          && buf_be_ff == SWBC_BE_WORD) |-> ##2 rsp_rdata_ff == $past(buf_data_ff, 2);
   endproperty
   a_hit_returns_buffer: assert property (p_hit_returns_buffer) else $error("stale read"); // R9

   property p_low_lane_first;
      @(posedge ref_clk) disable iff (!rstn)
         (wr_take && req_size == SWBC_SZ_BYTE) |-> $onehot(req_be) && req_be[req_ofs];
   endproperty
   a_low_lane_first: assert property (p_low_lane_first) else $error("lane order wrong"); // R3

   c_back_to_back_wr: cover property (@(posedge ref_clk) disable iff (!rstn) wr_take ##1 wr_take);
   c_read_hit: cover property (@(posedge ref_clk) disable iff (!rstn)
      rd_take && buf_valid_ff && buf_idx_ff == req_idx);
   c_half_write: cover property (@(posedge ref_clk) disable iff (!rstn)
      wr_take && req_size == SWBC_SZ_HALF);
endmodule : swbc_ctrl
`default_nettype wire

// ---- tb/swbc_core_model.sv ----
// core-side request model with a reference of committed and buffered bytes
`default_nettype none
module swbc_core_model
   import swbc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // request to controller
   output logic req_valid,
   output logic req_write,
   output swbc_size_e req_size,
   output logic [SWBC_ADDR_W-1:0] req_addr,
   output logic [31:0] req_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [64];
   logic [7:0] pend_d [4];
   logic [3:0] pend_be = 4'h0;
   logic [5:0] pend_a = 6'h00;
   logic [31:0] exp_q [$];
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_size = SWBC_SZ_WORD;
      req_addr = '0;
      req_wdata = '0;
   end
   // one request per call; calls back to back give one request per cycle
   task automatic access(input logic w, input swbc_size_e sz, input logic [5:0] a,
                         input logic [31:0] d);
      logic [3:0] be;
      logic [1:0] sh;
      logic [31:0] v;
      sh = (sz == SWBC_SZ_WORD) ? 2'h0 : a[1:0];
      be = (sz == SWBC_SZ_WORD) ? 4'hf : (sz == SWBC_SZ_HALF) ? 4'h3 << sh : 4'h1 << sh;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_size <= sz;
      req_addr <= {10'h000, a};
      req_wdata <= d;
      if (w) begin
         for (int i = 0; i < 4; i++) begin
            if (pend_be[i]) mem[{pend_a[5:2], 2'(i)}] = pend_d[i];
         end
         v = d << (8 * sh);
         for (int i = 0; i < 4; i++) pend_d[i] = v[8*i +: 8];
         pend_a = a;
         pend_be = be;
      end else begin
         for (int i = 0; i < 4; i++) begin
            v[8*i +: 8] = (pend_be[i] && pend_a[5:2] == a[5:2]) ? pend_d[i] :
                          mem[{a[5:2], 2'(i)}];
         end
         v = v >> (8 * sh);
         if (sz == SWBC_SZ_BYTE) v = v & 32'h0000_00ff;
         if (sz == SWBC_SZ_HALF) v = v & 32'h0000_ffff;
         exp_q.push_back(v);
      end
   endtask : access
   task automatic idle();
      @(posedge ref_clk);
      req_valid <= 1'b0;
   endtask : idle
   // a reset loses the buffered write, the array keeps its old bytes
   task automatic drop();
      pend_be = 4'h0;
   endtask : drop
endmodule : swbc_core_model
`default_nettype wire

// ---- tb/swbc_ctrl_tb_top.sv ----
// self-checking bench for the write-back buffered sram controller
`default_nettype none
module swbc_ctrl_tb_top
   import swbc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid;
   logic req_write;
   swbc_size_e req_size;
   logic [SWBC_ADDR_W-1:0] req_addr;
   logic [31:0] req_wdata;
   logic req_ready_ff;
   logic rsp_valid_ff;
   logic [31:0] rsp_rdata_ff;
   int bad_count = 0;
   int check_count = 0;
   always #25 ref_clk = ~ref_clk;
   swbc_core_model core (.ref_clk(ref_clk), .req_valid(req_valid), .req_write(req_write),
      .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata));
   swbc_ctrl #(.SIZE_KB(SWBC_KB_64)) dut (.ref_clk(ref_clk), .rstn(rstn),
      .req_valid(req_valid), .req_write(req_write), .req_size(req_size),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready_ff(req_ready_ff),
      .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff));
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp32
   task automatic cmp_flag(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_flag
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   // answers are matched in order against the notes of the request model
   always @(posedge ref_clk) begin
      if (rsp_valid_ff === 1'b1) begin
         if (core.exp_q.size() == 0) cmp32("spare answer", 32'h0, 32'h1);
         else cmp32("read data", core.exp_q.pop_front(), rsp_rdata_ff);
      end
   end
   task automatic fin(input string name);
      repeat (4) core.idle();
      cmp32("open answers", 32'h0, 32'(core.exp_q.size()));
      $display("test %s done", name);
   endtask : fin
   // callers leave the request lines idle first, so nothing is in flight here
   task automatic do_reset();
      rstn <= 1'b0;
      core.drop();
      repeat (4) @(posedge ref_clk);
      cmp_flag("ready in reset", 1'b0, req_ready_ff);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      cmp_flag("ready after reset", 1'b1, req_ready_ff);
   endtask : do_reset
   initial begin
      logic [31:0] r;
      swbc_size_e sz;
      logic [5:0] a;
      void'($urandom(32'h97a5));
      do_reset();
      for (int i = 0; i < 16; i++) core.access(1'b1, SWBC_SZ_WORD, 6'(4 * i), $urandom());
      for (int i = 0; i < 16; i++) core.access(1'b0, SWBC_SZ_WORD, 6'(4 * i), 32'h0);
      fin("fill");
      for (int i = 0; i < 8; i++) begin
         core.access(1'b1, SWBC_SZ_BYTE, 6'(32 + i), $urandom());
         core.access(1'b0, SWBC_SZ_WORD, 6'(32 + (i & 4)), 32'h0);
         core.access(1'b1, SWBC_SZ_HALF, 6'(40 + (i & 6)), $urandom());
         core.access(1'b0, SWBC_SZ_BYTE, 6'(40 + i), 32'h0);
      end
      fin("lanes");
      core.access(1'b1, SWBC_SZ_WORD, 6'h08, 32'h1111_2222);
      core.access(1'b1, SWBC_SZ_WORD, 6'h0c, 32'h3333_4444);
      core.access(1'b0, SWBC_SZ_WORD, 6'h0c, 32'h0);
      fin("buffer");
      do_reset();
      core.access(1'b0, SWBC_SZ_WORD, 6'h0c, 32'h0);
      core.access(1'b0, SWBC_SZ_WORD, 6'h08, 32'h0);
      core.access(1'b1, SWBC_SZ_WORD, 6'h10, 32'h5555_6666);
      core.access(1'b1, SWBC_SZ_BYTE, 6'h3f, 32'h0000_00a5);
      fin("drop");
      do_reset();
      core.access(1'b0, SWBC_SZ_WORD, 6'h10, 32'h0);
      fin("persist");
      // random mix, aligned, back to back
      for (int i = 0; i < 300; i++) begin
         r = $urandom();
         sz = swbc_size_e'(r[1:0] % 2'h3);
         a = r[7:2] & ((sz == SWBC_SZ_WORD) ? 6'h3c : (sz == SWBC_SZ_HALF) ? 6'h3e : 6'h3f);
         core.access(r[8], sz, a, $urandom());
      end
      fin("random");
      give_verdict();
   end
   initial begin
      #(5000 * 50);
      bad_count++;
      give_verdict();
   end
endmodule : swbc_ctrl_tb_top
`default_nettype wire
